/* File: core/point_table_auto_positioning.sv */
/*
 * Point-table automatic positioning sequencer: filters the controller's start
 * bits, starts a table, and chains tables by auxiliary code and dwell.
 * Assumes a motion engine that moves to the requested table and reports done,
 * and a table store that answers the table number combinationally.
 */
// Behaviour
// - Absolute method: forward start while stopped and energised begins positioning.
// - Incremental method: forward or reverse start while stopped and energised begins.
// - Command inputs are recognised only after the configured filter time.
// - Continuous mode runs consecutive tables ascending after one start.
// - Absolute method: code 1 or 3 continues after its dwell, a dwell of zero ms included.
// - Absolute method chains may reverse direction by each table's target.
// - Code 0 single, 1 next, 8 loop to start, 9 to table 1; code 1 on table 255 errors.
`timescale 1ns/1ps
`include "pt_auto_cfg.svh"
module point_table_auto_positioning #(
    parameter int FILTER_MAX_MS = 15,
    parameter int CYC_PER_MS = `CYC_PER_MS
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire pt_auto_pkg::cmd_bits_t cmdBits,
    input wire logic [7:0] table_select_word,
    input wire logic command_method_cfg,
    input wire logic [3:0] input_filter_cfg,
    input wire logic motorStopped,
    input wire logic moveDone,
    input wire pt_auto_pkg::table_entry_t tableEntry,
    output logic [7:0] tableAddr,
    output logic moveStart,
    output logic moveReverse,
    output logic [7:0] table_number_out,
    output logic travel_done_flag,
    output logic drive_ready_flag,
    output logic seqError,
    output logic seqBusy
);
    import pt_auto_pkg::*;

    // Millisecond tick divider.
    logic [17:0] msCnt_q, msCnt_d;
    logic msTick;
    always_comb begin
        msTick = (msCnt_q == 18'(CYC_PER_MS - 1));
        msCnt_d = msTick ? 18'h0_0000 : msCnt_q + 18'h0_0001;
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            msCnt_q <= 18'h0_0000;
        end else begin
            msCnt_q <= msCnt_d;
        end
    end

    // Two-stage synchroniser for the command bits and selection word.
    logic [3:0] sync1_q, sync2_q;
    logic [7:0] selSync1_q, selSync2_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            selSync1_q <= 8'h00;
            selSync2_q <= 8'h00;
        end else begin
            sync1_q <= cmdBits;
            sync2_q <= sync1_q;
            selSync1_q <= table_select_word;
            selSync2_q <= selSync1_q;
        end
    end

    // Filter: a bit change is accepted once stable for the filter time in ms.
    logic [3:0] filt_q, filt_d;
    logic [3:0] stab_q [4];
    logic [3:0] stab_d [4];
    logic [3:0] filtMs;
    always_comb begin
        // A setting above the supported maximum is held at that maximum.
        filtMs = (32'(input_filter_cfg) > FILTER_MAX_MS) ? 4'(FILTER_MAX_MS) : input_filter_cfg;
        for (int i = 0; i < 4; i++) begin
            filt_d[i] = filt_q[i];
            stab_d[i] = stab_q[i];
            if (sync2_q[i] == filt_q[i]) begin
                stab_d[i] = 4'h0;
            end else if (stab_q[i] >= filtMs && (msTick || filtMs == 4'h0)) begin
                // The first counted tick may be partial, so accept on the tick after the count.
                filt_d[i] = sync2_q[i];
                stab_d[i] = 4'h0;
            end else if (msTick) begin
                stab_d[i] = stab_q[i] + 4'h1;
            end
        end
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            filt_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                stab_q[i] <= 4'h0;
            end
        end else begin
            filt_q <= filt_d;
            stab_q <= stab_d;
        end
    end

    cmd_bits_t cmdF;
    logic fwdPrev_q, revPrev_q;
    logic fwdRise, revRise;
    always_comb begin
        cmdF = cmd_bits_t'(filt_q);
        fwdRise = cmdF.fwdStartReq & ~fwdPrev_q;
        revRise = cmdF.revStartReq & ~revPrev_q;
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fwdPrev_q <= 1'b0;
            revPrev_q <= 1'b0;
        end else begin
            fwdPrev_q <= cmdF.fwdStartReq;
            revPrev_q <= cmdF.revStartReq;
        end
    end

    // Sequencer state.
    seq_state_t state_q, state_d;
    logic [7:0] cur_q, cur_d, startTbl_q, startTbl_d;
    logic [15:0] dwell_q, dwell_d;
    logic rev_q, rev_d, start_q, start_d, done_q, done_d, err_q, err_d;
    logic [7:0] out_q, out_d;
    logic canStart, ready;

    always_comb begin
        ready = cmdF.driveEnergiseReq & cmdF.autoManualSel;
        // Absolute accepts forward only; incremental accepts either.
        canStart = ready && motorStopped &&
            (fwdRise || (command_method_cfg && revRise));
        state_d = state_q;
        cur_d = cur_q;
        startTbl_d = startTbl_q;
        dwell_d = dwell_q;
        rev_d = rev_q;
        start_d = 1'b0;
        done_d = done_q;
        err_d = err_q;
        out_d = out_q;
        unique case (state_q)
            ST_IDLE, ST_DONE, ST_ERROR: begin
                if (canStart) begin
                    state_d = ST_MOVE;
                    cur_d = selSync2_q;
                    startTbl_d = selSync2_q;
                    out_d = selSync2_q;
                    rev_d = command_method_cfg & ~fwdRise;
                    start_d = 1'b1;
                    done_d = 1'b0;
                    err_d = 1'b0;
                end
            end
            ST_MOVE: begin
                if (!ready) begin
                    state_d = ST_IDLE;
                end else if (moveDone) begin
                    unique case (tableEntry.auxCode)
                        `AUX_NEXT_ABS, `AUX_NEXT_INC, `AUX_LOOP_START, `AUX_LOOP_ONE: begin
                            if (tableEntry.auxCode == `AUX_NEXT_ABS && cur_q == `TABLE_LAST) begin
                                state_d = ST_ERROR;
                                err_d = 1'b1;
                            end else begin
                                state_d = ST_DWELL;
                                dwell_d = tableEntry.dwellMs;
                            end
                        end
                        default: begin
                            state_d = ST_DONE;
                            done_d = 1'b1;
                        end
                    endcase
                end
            end
            ST_DWELL: begin
                if (!ready) begin
                    state_d = ST_IDLE;
                end else if (dwell_q == 16'h0000 && (msTick || tableEntry.dwellMs == 16'h0000)) begin
                    // The first tick may come early; waiting one more keeps the whole dwell.
                    state_d = ST_MOVE;
                    start_d = 1'b1;
                    // Next table: ascending, or loop back to start or table 1.
                    unique case (tableEntry.auxCode)
                        `AUX_LOOP_START: cur_d = startTbl_q;
                        `AUX_LOOP_ONE: cur_d = `TABLE_FIRST;
                        default: cur_d = cur_q + 8'h01;
                    endcase
                    out_d = cur_d;
                end else if (msTick) begin
                    dwell_d = dwell_q - 16'h0001;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            cur_q <= 8'h00;
            startTbl_q <= 8'h00;
            dwell_q <= 16'h0000;
            rev_q <= 1'b0;
            start_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            out_q <= 8'h00;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            startTbl_q <= startTbl_d;
            dwell_q <= dwell_d;
            rev_q <= rev_d;
            start_q <= start_d;
            done_q <= done_d;
            err_q <= err_d;
            out_q <= out_d;
        end
    end

    // Target of each table sets direction in absolute chains; motion engine resolves it.
    always_comb begin
        tableAddr = cur_q;
        moveStart = start_q;
        moveReverse = rev_q;
        table_number_out = out_q;
        travel_done_flag = done_q;
        drive_ready_flag = cmdF.driveEnergiseReq;
        seqError = err_q;
        seqBusy = (state_q == ST_MOVE) || (state_q == ST_DWELL);
    end

    start_abs_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_q == ST_IDLE && !command_method_cfg && revRise && !fwdRise) |=> !start_q)
        else $error("reverse start accepted under absolute method");
    start_inc_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_q == ST_IDLE && command_method_cfg && revRise && ready && motorStopped) |=> (start_q && rev_q))
        else $error("reverse start ignored under incremental method");
    filter_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (filt_q != $past(filt_q)) |-> ($past(stab_q[0]) >= filtMs || $past(stab_q[1]) >= filtMs
        || $past(stab_q[2]) >= filtMs || $past(stab_q[3]) >= filtMs))
        else $error("input accepted before filter time");
    chain_next_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_q == ST_DWELL && state_d == ST_MOVE && tableEntry.auxCode == `AUX_NEXT_INC)
        |=> cur_q == $past(cur_q) + 8'h01)
        else $error("chain did not step to next table");
    dwell_go_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_q == ST_MOVE && ready && moveDone && cur_q != `TABLE_LAST &&
        (tableEntry.auxCode == `AUX_NEXT_ABS || tableEntry.auxCode == `AUX_NEXT_INC)) |=> state_q == ST_DWELL)
        else $error("continuing table did not enter dwell");
    dwell_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_q == ST_DWELL && ready && dwell_q != 16'h0000) |=> state_q == ST_DWELL)
        else $error("dwell cut short");
    chain_end_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_q == ST_MOVE && ready && moveDone && tableEntry.auxCode == `AUX_SINGLE_INC)
        |=> (state_q == ST_DONE && travel_done_flag))
        else $error("last table did not end chain");
    loop_one_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_q == ST_DWELL && state_d == ST_MOVE && tableEntry.auxCode == `AUX_LOOP_ONE)
        |=> (cur_q == `TABLE_FIRST && start_q))
        else $error("loop to table one failed");
    last_err_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_q == ST_MOVE && ready && moveDone && cur_q == `TABLE_LAST && tableEntry.auxCode == `AUX_NEXT_ABS)
        |=> seqError)
        else $error("next on last table did not raise error");
    out_num_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        start_q |-> table_number_out == cur_q)
        else $error("table number output mismatch");

    run_cov: cover property (@(posedge sys_clk) disable iff (!arst_n) state_q == ST_MOVE ##1 state_q == ST_DWELL);
    done_cov: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(travel_done_flag));
    err_cov: cover property (@(posedge sys_clk) disable iff (!arst_n) $rose(seqError));
endmodule

/* File: core/pt_auto_cfg.svh */
/*
 * Timing constants and codes for the point-table auto-positioning sequencer.
 * Assumes a 250 MHz system clock.
 */
`ifndef PT_AUTO_CFG_SVH
`define PT_AUTO_CFG_SVH
`define CLK_MHZ 250
`define MS_NS 1000000
`define CLK_PERIOD_NS 4
`define CYC_PER_MS (`MS_NS / `CLK_PERIOD_NS)
`define AUX_SINGLE_ABS 4'h0
`define AUX_NEXT_ABS 4'h1
`define AUX_SINGLE_INC 4'h2
`define AUX_NEXT_INC 4'h3
`define AUX_LOOP_START 4'h8
`define AUX_LOOP_ONE 4'h9
`define TABLE_LAST 8'hFF
`define TABLE_FIRST 8'h01
`endif

/* File: core/pt_auto_pkg.sv */
/*
 * Types for the point-table auto-positioning sequencer.
 * Assumes nothing beyond the configuration header.
 */
package pt_auto_pkg;
    typedef struct packed {
        logic [15:0] dwellMs;
        logic [3:0] auxCode;
    } table_entry_t;
    typedef struct packed {
        logic driveEnergiseReq;
        logic fwdStartReq;
        logic revStartReq;
        logic autoManualSel;
    } cmd_bits_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_MOVE = 3'b001,
        ST_DWELL = 3'b010,
        ST_DONE = 3'b011,
        ST_ERROR = 3'b100
    } seq_state_t;
endpackage

/* File: tb/motion_model.sv */
/*
 * Motion engine and table store beside the sequencer: answers the entry at
 * tableAddr at once and finishes each move DELAY cycles after its start.
 * Assumes the bench fills tbl before starting any table.
 */
`timescale 1ns/1ps
module motion_model #(
    parameter int DELAY = 5
) (
    input wire logic sys_clk,
    input wire logic [7:0] tableAddr,
    input wire logic moveStart,
    output pt_auto_pkg::table_entry_t tableEntry,
    output logic moveDone,
    output logic motorStopped
);
    import pt_auto_pkg::*;
    table_entry_t tbl [256];
    int cnt = 0;
    initial moveDone = 1'b0;
    // The table store answers combinationally; the motor rests when no move runs.
    assign tableEntry = tbl[tableAddr];
    assign motorStopped = (cnt == 0);
    // Each start runs a move that ends with a one-cycle done pulse.
    always @(posedge sys_clk) begin
        moveDone <= 1'b0;
        if (moveStart === 1'b1) begin
            cnt <= DELAY;
        end else if (cnt == 1) begin
            moveDone <= 1'b1;
            cnt <= 0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

/* File: tb/point_table_auto_positioning_bench.sv */
/*
 * Bench for the point-table sequencer: each task starts tables and judges
 * the starts, flags and timing that come back.
 * Assumes motion_model as the motion engine, one ms shortened to CPM cycles.
 */
`timescale 1ns/1ps
`include "pt_auto_cfg.svh"
module point_table_auto_positioning_bench;
    import pt_auto_pkg::*;
    localparam int CPM = 10;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    cmd_bits_t cmd = 4'h9; // Energised and in auto mode.
    logic [7:0] sel = 8'h00;
    logic method = 1'b0;
    logic [3:0] filt = 4'h0;
    logic motorStopped, moveDone, moveStart, moveReverse;
    logic travel_done_flag, drive_ready_flag, seqError, seqBusy;
    table_entry_t tableEntry;
    logic [7:0] tableAddr, table_number_out;
    logic [7:0] seen[$];
    int stamp[$];
    int cyc = 0;
    int riseAt = 0;
    int miscompares = 0;
    int n_compared = 0;
    always #2 sys_clk = ~sys_clk;
    point_table_auto_positioning #(.FILTER_MAX_MS(15), .CYC_PER_MS(CPM)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
        .cmdBits(cmd), .table_select_word(sel), .command_method_cfg(method), .input_filter_cfg(filt),
        .motorStopped(motorStopped), .moveDone(moveDone), .tableEntry(tableEntry), .tableAddr(tableAddr),
        .moveStart(moveStart), .moveReverse(moveReverse), .table_number_out(table_number_out),
        .travel_done_flag(travel_done_flag), .drive_ready_flag(drive_ready_flag), .seqError(seqError),
        .seqBusy(seqBusy));
    motion_model partner (.sys_clk(sys_clk), .tableAddr(tableAddr), .moveStart(moveStart),
        .tableEntry(tableEntry), .moveDone(moveDone), .motorStopped(motorStopped));
    // Logs every table started, with the cycle it started in.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (moveStart === 1'b1) begin
            seen.push_back(tableAddr);
            stamp.push_back(cyc);
        end
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Selects a table first, then holds one start bit for 6 ms.
    task automatic go(input logic [7:0] s, input logic rev);
        seen.delete();
        stamp.delete();
        sel = s;
        cycles(4);
        riseAt = cyc;
        cmd.fwdStartReq = !rev;
        cmd.revStartReq = rev;
        cycles(6 * CPM);
        cmd.fwdStartReq = 1'b0;
        cmd.revStartReq = 1'b0;
    endtask
    // Waits, bounded, for n starts, then long enough for any stray one.
    task automatic settle(input int n);
        int k;
        for (k = 0; k < 3000 && seen.size() < n; k++) cycles(1);
        if (seen.size() < n) begin
            miscompares++;
            tally_and_finish();
        end
        cycles(40);
    endtask
    // Absolute chain 1-2-3 on one start, each dwell honoured, last dwell ignored.
    task automatic abs_chain();
        partner.tbl[1] = '{16'h0001, `AUX_NEXT_ABS};
        partner.tbl[2] = '{16'h0002, `AUX_NEXT_INC};
        partner.tbl[3] = '{16'h0007, `AUX_SINGLE_ABS};
        go(8'h01, 1'b0);
        settle(3);
        chk("tables run", 16'h0003, 16'(seen.size()));
        for (int i = 1; i <= 3; i++) chk("table", 16'(i), {8'h00, seen[i - 1]});
        chk("dwell one", 16'h0001, 16'(stamp[1] - stamp[0] >= 5 + CPM));
        chk("dwell two", 16'h0001, 16'(stamp[2] - stamp[1] >= 5 + 2 * CPM));
        chk("done", 16'h0001, {15'h0000, travel_done_flag});
        chk("table out", 16'h0003, {8'h00, table_number_out});
        partner.tbl[5] = '{16'h0000, `AUX_SINGLE_INC};
        go(8'h05, 1'b1);
        cycles(40);
        chk("reverse under absolute", 16'h0000, 16'(seen.size()));
    endtask
    // Incremental method starts on either bit, with the matching direction.
    task automatic inc_starts();
        method = 1'b1;
        for (int r = 0; r < 2; r++) begin
            go(8'h05, r[0]);
            settle(1);
            chk("single table", 16'h0005, {8'h00, seen[0]});
            chk("single run", 16'h0001, 16'(seen.size()));
            chk("direction", 16'(r), {15'h0000, moveReverse});
        end
        method = 1'b0;
    endtask
    // Error on table 255, loop to table 1, loop to the start table, abort.
    task automatic codes();
        partner.tbl[254] = '{16'h0001, `AUX_NEXT_ABS};
        partner.tbl[255] = '{16'h0001, `AUX_NEXT_ABS};
        go(8'hFE, 1'b0);
        settle(2);
        chk("last table", 16'h00FF, {8'h00, seen[1]});
        chk("error", 16'h0001, {15'h0000, seqError});
        partner.tbl[20] = '{16'h0001, `AUX_LOOP_ONE};
        go(8'h14, 1'b0);
        settle(4);
        chk("loop to one", 16'h0001, {8'h00, seen[1]});
        chk("error cleared", 16'h0000, {15'h0000, seqError});
        partner.tbl[30] = '{16'h0001, `AUX_NEXT_ABS};
        partner.tbl[31] = '{16'h0001, `AUX_LOOP_START};
        go(8'h1E, 1'b0);
        settle(3);
        chk("loop to start", 16'h001E, {8'h00, seen[2]});
        cmd.autoManualSel = 1'b0;
        cycles(100);
        chk("aborted", 16'h0000, {15'h0000, seqBusy});
        cmd.autoManualSel = 1'b1;
        cycles(20);
    endtask
    // A 2 ms filter holds the start back by at least 2 ms.
    task automatic filter_delay();
        filt = 4'h2;
        cycles(100);
        go(8'h05, 1'b0);
        settle(1);
        chk("filter delay", 16'h0001, 16'(stamp[0] - riseAt >= 2 * CPM && stamp[0] - riseAt <= 4 * CPM));
        filt = 4'h0;
    endtask
    // Reset for 5 cycles, then every scenario in turn.
    initial begin
        cycles(5);
        arst_n = 1'b1;
        cycles(20);
        chk("ready", 16'h0001, {15'h0000, drive_ready_flag});
        abs_chain();
        inc_starts();
        codes();
        filter_delay();
        tally_and_finish();
    end
endmodule
